// >>> core/accfc_defs.vh
// Register offsets, field positions, reset values and match constants.
`ifndef ACCFC_DEFS_VH
`define ACCFC_DEFS_VH

`define ACCFC_OFF_AGGR 12'h000
`define ACCFC_OFF_TYPEQ 12'h004
`define ACCFC_OFF_STATUS 12'h008
`define ACCFC_OFF_ADDRQ 12'h010
`define ACCFC_ADDRQ_WORDS 6
`define ACCFC_OFF_PORT 12'h100
`define ACCFC_PORT_SHIFT 4
`define ACCFC_SUB_TYPES 2'h0
`define ACCFC_SUB_BPDU 2'h1
`define ACCFC_SUB_GARP 2'h2
`define ACCFC_SUB_CCM 2'h3

`define ACCFC_AG_DMAC 0
`define ACCFC_AG_SMAC 1
`define ACCFC_AG_FLOW 2
`define ACCFC_AG_IP4 3
`define ACCFC_AG_L4 4
`define ACCFC_AG_RAND 5
`define ACCFC_AGGR_RST 6'h00

`define ACCFC_TY_ALLBR 0
`define ACCFC_TY_IGMP 1
`define ACCFC_TY_MLD 2
`define ACCFC_TY_IPMC 3
`define ACCFC_TY_SRC 4
`define ACCFC_TYPE_RST 5'h00
`define ACCFC_TYPEQ_RST 15'h0000
`define ACCFC_ADDRQ_RST 24'h000000
`define ACCFC_PER_ADDR_RST 16'h0000

`define ACCFC_LFSR_SEED 16'hACE1
`define ACCFC_RSV_PFX 40'h0180C20000
`define ACCFC_IP4MC_PFX 25'h00200BC
`define ACCFC_IP6MC_PFX 16'h3333
`define ACCFC_PROTO_IGMP 8'h02
`define ACCFC_NH_HOPBYHOP 8'h00
`define ACCFC_OPT_RTRALERT 8'h05
`define ACCFC_OPT_LEN 8'h02
`define ACCFC_OPT_MLD 16'h0000
`define ACCFC_IP4_LOCAL 24'hE00000

`define ACCFC_RESP_OKAY 2'h0
`define ACCFC_RESP_SLVERR 2'h2

`endif

// >>> core/accfc_classify.v
// Aggregation code and CPU forwarding classifier with AXI4-Lite registers.
// How it works
// RQ1 - DMAC low 12 bits feed code when enabled
// RQ2 - SMAC low 12 bits feed code when enabled
// RQ3 - IPv6 flow label 20 bits feed code
// RQ4 - IPv4 SIP and DIP low bytes feed code
// RQ5 - L4 port low bytes feed code
// RQ6 - Random mode replaces frame info with LFSR
// RQ7 - XOR contributions into 4-bit code
// RQ8 - Each contribution enabled by one global register
// RQ9 - All CPU events ORed into readable mask
// RQ10 - Queue mask has eight bits, one per queue
// RQ11 - Redirect removes all front ports
// RQ12 - Copy keeps normal front port forwarding
// RQ13 - Reserved bridge range is BPDU, redirected
// RQ14 - All-bridges address redirected to CPU
// RQ15 - GARP application range redirected to CPU
// RQ16 - CCM and link trace range redirected
// RQ17 - IGMP in low IPv4 multicast MAC redirected
// RQ18 - MLD router alert hop-by-hop frames redirected
// RQ19 - Non-IGMP 224.0.0.x multicast copied to CPU
// RQ20 - Source-port forwarding copies every frame
// RQ21 - Per-port enables per type and address
// RQ22 - Software selects queue per type and address
// RQ23 - Unmatched or disabled frames add no CPU queue bits
`timescale 1ns/1ps
`default_nettype none
`include "accfc_defs.vh"

module accfc_classify #(
  parameter NPORTS = 26,
  parameter PORT_W = 5
) (
  input wire clk_sys, // System clock, 100 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire [11:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [11:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output wire [31:0] s_axi_rdata, // Read data
  output wire [1:0] s_axi_rresp, // Read response
  output wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire frmValid, // Parsed frame fields valid, one cycle
  input wire [PORT_W-1:0] frmPort, // Ingress physical port
  input wire [47:0] frmDmac, // Destination MAC
  input wire [47:0] frmSmac, // Source MAC
  input wire frmIsIp4, // Frame is IPv4
  input wire frmIsIp6, // Frame is IPv6
  input wire frmL4Valid, // TCP or UDP ports present
  input wire [7:0] frmIpProto, // IPv4 protocol or IPv6 next header
  input wire [31:0] frmSip, // IPv4 source address
  input wire [31:0] frmDip, // IPv4 destination address
  input wire [19:0] frmFlowLabel, // IPv6 flow label
  input wire [15:0] frmSport, // L4 source port
  input wire [15:0] frmDport, // L4 destination port
  input wire [7:0] frmOptType, // First hop-by-hop option type
  input wire [7:0] frmOptLen, // First hop-by-hop option data length
  input wire [15:0] frmOptData, // First hop-by-hop option data
  input wire [7:0] extCpuQueueMask, // CPU queue events from elsewhere
  input wire [NPORTS:0] fwdMaskIn, // Forward mask, CPU port on top
  output wire resValid, // Result valid, one cycle
  output wire [3:0] aggrCode, // Link aggregation code
  output wire [7:0] cpuQueueMask, // Final CPU extraction queue mask
  output wire [NPORTS:0] forwardPortMask, // Final forward mask
  output wire cpuRedirect, // Frame redirected to CPU
  output wire cpuCopy // Frame copied to CPU
);

  function [31:0] mergeStrb;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0] strb;
    integer i;
    begin
      mergeStrb = oldV;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          mergeStrb[i*8 +: 8] = newV[i*8 +: 8];
        end
      end
    end
  endfunction

  function [3:0] fold20;
    input [19:0] v;
    begin
      fold20 = v[3:0] ^ v[7:4] ^ v[11:8] ^ v[15:12] ^ v[19:16];
    end
  endfunction

  // ---------------- AXI4-Lite write channel ----------------
  reg awHave_r;
  reg wHave_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg [11:0] wrAddr_r;
  reg [31:0] wrData_r;
  reg [3:0] wrStrb_r;
  wire doWrite = awHave_r && wHave_r && !bvalid_r;
  wire wrPortHit;
  wire wrGlobHit;
  wire [11:0] wrPortOff = wrAddr_r - `ACCFC_OFF_PORT;
  wire [7:0] wrPortIdx = wrPortOff[11:4];

  assign s_axi_awready = !awHave_r;
  assign s_axi_wready = !wHave_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign wrPortHit = wrAddr_r >= `ACCFC_OFF_PORT &&
    wrPortIdx < NPORTS;
  assign wrGlobHit = wrAddr_r[11:2] == `ACCFC_OFF_AGGR >> 2 ||
    wrAddr_r[11:2] == `ACCFC_OFF_TYPEQ >> 2 ||
    wrAddr_r[11:2] == `ACCFC_OFF_STATUS >> 2 ||
    (wrAddr_r >= `ACCFC_OFF_ADDRQ &&
     wrAddr_r < `ACCFC_OFF_ADDRQ + 4 * `ACCFC_ADDRQ_WORDS);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `ACCFC_RESP_OKAY;
      wrAddr_r <= 12'h000;
      wrData_r <= 32'h00000000;
      wrStrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHave_r) begin
        awHave_r <= 1'b1;
        wrAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_r) begin
        wHave_r <= 1'b1;
        wrData_r <= s_axi_wdata;
        wrStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= (wrPortHit || wrGlobHit) ? `ACCFC_RESP_OKAY :
          `ACCFC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ---------------- Global configuration ----------------
  reg [5:0] aggrCfg_r;
  reg [14:0] typeQ_r;
  wire [31:0] wrAggrVal = mergeStrb({26'h0000000, aggrCfg_r},
    wrData_r, wrStrb_r);
  wire [31:0] wrTypeQVal = mergeStrb({17'h00000, typeQ_r},
    wrData_r, wrStrb_r);

  // RQ8 global enables
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      aggrCfg_r <= `ACCFC_AGGR_RST;
      typeQ_r <= `ACCFC_TYPEQ_RST;
    end else if (doWrite) begin
      if (wrAddr_r[11:2] == `ACCFC_OFF_AGGR >> 2) begin
        aggrCfg_r <= wrAggrVal[5:0];
      end else if (wrAddr_r[11:2] == `ACCFC_OFF_TYPEQ >> 2) begin
        typeQ_r <= wrTypeQVal[14:0];
      end
    end
  end

  // Eight 3-bit queue selections per word, BPDU then GARP then CCM.
  wire [24*`ACCFC_ADDRQ_WORDS-1:0] addrQFlat;
  genvar gw;
  generate
    for (gw = 0; gw < `ACCFC_ADDRQ_WORDS; gw = gw + 1) begin : gAddrQ
      reg [23:0] q_r;
      wire [31:0] wv = mergeStrb({8'h00, q_r}, wrData_r, wrStrb_r);
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          q_r <= `ACCFC_ADDRQ_RST;
        end else if (doWrite &&
                     wrAddr_r[11:2] == (`ACCFC_OFF_ADDRQ >> 2) + gw) begin
          q_r <= wv[23:0];
        end
      end
      assign addrQFlat[gw*24 +: 24] = q_r;
    end
  endgenerate

  // ---------------- Per-port enables ----------------
  wire [5*NPORTS-1:0] typeEnaFlat;
  wire [16*NPORTS-1:0] bpduEnaFlat;
  wire [16*NPORTS-1:0] garpEnaFlat;
  wire [16*NPORTS-1:0] ccmEnaFlat;
  genvar gp;
  generate
    for (gp = 0; gp < NPORTS; gp = gp + 1) begin : gPort
      reg [4:0] type_r;
      reg [15:0] bpdu_r;
      reg [15:0] garp_r;
      reg [15:0] ccm_r;
      wire sel = doWrite && wrPortHit && wrPortIdx == gp;
      wire [31:0] tv = mergeStrb({27'h0000000, type_r}, wrData_r,
        wrStrb_r);
      wire [31:0] bv = mergeStrb({16'h0000, bpdu_r}, wrData_r, wrStrb_r);
      wire [31:0] gv = mergeStrb({16'h0000, garp_r}, wrData_r, wrStrb_r);
      wire [31:0] cv = mergeStrb({16'h0000, ccm_r}, wrData_r, wrStrb_r);
      // RQ21 per-port enables
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          type_r <= `ACCFC_TYPE_RST;
          bpdu_r <= `ACCFC_PER_ADDR_RST;
          garp_r <= `ACCFC_PER_ADDR_RST;
          ccm_r <= `ACCFC_PER_ADDR_RST;
        end else if (sel) begin
          if (wrAddr_r[3:2] == `ACCFC_SUB_TYPES) begin
            type_r <= tv[4:0];
          end else if (wrAddr_r[3:2] == `ACCFC_SUB_BPDU) begin
            bpdu_r <= bv[15:0];
          end else if (wrAddr_r[3:2] == `ACCFC_SUB_GARP) begin
            garp_r <= gv[15:0];
          end else begin
            ccm_r <= cv[15:0];
          end
        end
      end
      assign typeEnaFlat[gp*5 +: 5] = type_r;
      assign bpduEnaFlat[gp*16 +: 16] = bpdu_r;
      assign garpEnaFlat[gp*16 +: 16] = garp_r;
      assign ccmEnaFlat[gp*16 +: 16] = ccm_r;
    end
  endgenerate

  // ---------------- Classification ----------------
  reg [15:0] lfsr_r;
  reg resValid_r;
  reg [3:0] aggrCode_r;
  reg [7:0] cpuQueueMask_r;
  reg [NPORTS:0] fwdMask_r;
  reg redirect_r;
  reg copy_r;

  // Out-of-range ports see no enables rather than an undefined slice.
  wire portOk = frmPort < NPORTS;
  wire [4:0] pType = portOk ? typeEnaFlat[frmPort*5 +: 5] : 5'h00;
  wire [15:0] pBpdu = portOk ? bpduEnaFlat[frmPort*16 +: 16] : 16'h0000;
  wire [15:0] pGarp = portOk ? garpEnaFlat[frmPort*16 +: 16] : 16'h0000;
  wire [15:0] pCcm = portOk ? ccmEnaFlat[frmPort*16 +: 16] : 16'h0000;

  wire rsvHi = frmDmac[47:8] == `ACCFC_RSV_PFX;
  // RQ13 BPDU range
  wire bpduHit = rsvHi && frmDmac[7:4] == 4'h0 && pBpdu[frmDmac[3:0]];
  // RQ14 all-bridges address
  wire allbrHit = rsvHi && frmDmac[7:0] == 8'h10 &&
    pType[`ACCFC_TY_ALLBR];
  // RQ15 GARP range
  wire garpHit = rsvHi && frmDmac[7:4] == 4'h2 && pGarp[frmDmac[3:0]];
  // RQ16 CCM range
  wire ccmHit = rsvHi && frmDmac[7:4] == 4'h3 && pCcm[frmDmac[3:0]];
  wire ip4Mc = frmIsIp4 && frmDmac[47:23] == `ACCFC_IP4MC_PFX;
  // RQ17 IGMP
  wire igmpHit = ip4Mc && frmIpProto == `ACCFC_PROTO_IGMP &&
    pType[`ACCFC_TY_IGMP];
  // RQ18 MLD router alert
  wire mldHit = frmIsIp6 && frmDmac[47:32] == `ACCFC_IP6MC_PFX &&
    frmIpProto == `ACCFC_NH_HOPBYHOP &&
    frmOptType == `ACCFC_OPT_RTRALERT && frmOptLen == `ACCFC_OPT_LEN &&
    frmOptData == `ACCFC_OPT_MLD && pType[`ACCFC_TY_MLD];
  // RQ19 local control multicast
  wire ipmcHit = ip4Mc && frmIpProto != `ACCFC_PROTO_IGMP &&
    frmDip[31:8] == `ACCFC_IP4_LOCAL && pType[`ACCFC_TY_IPMC];
  // RQ20 source-port copy
  wire srcHit = pType[`ACCFC_TY_SRC];

  // RQ22 per-address queue lookup
  wire [1:0] rsvGrp = frmDmac[5] ? (frmDmac[4] ? 2'h2 : 2'h1) : 2'h0;
  wire [5:0] rsvIdx = {rsvGrp, frmDmac[3:0]};
  wire [2:0] rsvQ = addrQFlat[rsvIdx*3 +: 3];
  wire rsvAny = bpduHit || garpHit || ccmHit;

  // RQ11 redirect set
  wire redirect = rsvAny || allbrHit || igmpHit || mldHit;
  // RQ12 copy set
  wire copy = ipmcHit || srcHit;

  // RQ22 type queues
  wire [7:0] clsMask =
    (rsvAny ? 8'h01 << rsvQ : 8'h00) |
    (allbrHit ? 8'h01 << typeQ_r[3*`ACCFC_TY_ALLBR +: 3] : 8'h00) |
    (igmpHit ? 8'h01 << typeQ_r[3*`ACCFC_TY_IGMP +: 3] : 8'h00) |
    (mldHit ? 8'h01 << typeQ_r[3*`ACCFC_TY_MLD +: 3] : 8'h00) |
    (ipmcHit ? 8'h01 << typeQ_r[3*`ACCFC_TY_IPMC +: 3] : 8'h00) |
    (srcHit ? 8'h01 << typeQ_r[3*`ACCFC_TY_SRC +: 3] : 8'h00);

  // RQ9 OR of all CPU events
  wire [7:0] finalMask = clsMask | extCpuQueueMask;

  // RQ1 RQ2 RQ3 RQ4 RQ5 contributions
  wire [3:0] cDmac = aggrCfg_r[`ACCFC_AG_DMAC] ?
    fold20({8'h00, frmDmac[11:0]}) : 4'h0;
  wire [3:0] cSmac = aggrCfg_r[`ACCFC_AG_SMAC] ?
    fold20({8'h00, frmSmac[11:0]}) : 4'h0;
  wire [3:0] cFlow = (aggrCfg_r[`ACCFC_AG_FLOW] && frmIsIp6) ?
    fold20(frmFlowLabel) : 4'h0;
  wire [3:0] cIp4 = (aggrCfg_r[`ACCFC_AG_IP4] && frmIsIp4) ?
    fold20({4'h0, frmSip[7:0], frmDip[7:0]}) : 4'h0;
  wire [3:0] cL4 = (aggrCfg_r[`ACCFC_AG_L4] && frmL4Valid &&
    (frmIsIp4 || frmIsIp6)) ?
    fold20({4'h0, frmSport[7:0], frmDport[7:0]}) : 4'h0;
  // RQ6 random replaces frame data
  // RQ7 XOR to four bits
  wire [3:0] code = aggrCfg_r[`ACCFC_AG_RAND] ? lfsr_r[3:0] :
    (cDmac ^ cSmac ^ cFlow ^ cIp4 ^ cL4);

  // The LFSR runs every cycle so consecutive frames see unrelated values.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      lfsr_r <= `ACCFC_LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0],
        lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      resValid_r <= 1'b0;
      aggrCode_r <= 4'h0;
      cpuQueueMask_r <= 8'h00;
      fwdMask_r <= {(NPORTS+1){1'b0}};
      redirect_r <= 1'b0;
      copy_r <= 1'b0;
    end else begin
      resValid_r <= frmValid;
      if (frmValid) begin
        aggrCode_r <= code;
        // RQ10 eight-bit mask
        cpuQueueMask_r <= finalMask;
        redirect_r <= redirect;
        copy_r <= copy;
        // RQ11 front ports cleared on redirect
        // RQ23 CPU port set by an event, or kept from fwdMaskIn when not redirected
        if (redirect) begin
          fwdMask_r <= {(finalMask != 8'h00), {NPORTS{1'b0}}};
        end else begin
          fwdMask_r <= {fwdMaskIn[NPORTS] | (finalMask != 8'h00),
            fwdMaskIn[NPORTS-1:0]};
        end
      end
    end
  end

  assign resValid = resValid_r;
  assign aggrCode = aggrCode_r;
  assign cpuQueueMask = cpuQueueMask_r;
  assign forwardPortMask = fwdMask_r;
  assign cpuRedirect = redirect_r;
  assign cpuCopy = copy_r;

  // ---------------- AXI4-Lite read channel ----------------
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [31:0] rdMux;
  reg rdOk;
  wire [11:0] rdPortOff = s_axi_araddr - `ACCFC_OFF_PORT;
  wire [7:0] rdPortIdx = rdPortOff[11:4];
  wire rdPortHit = s_axi_araddr >= `ACCFC_OFF_PORT && rdPortIdx < NPORTS;
  wire [3:0] rdWord = s_axi_araddr[5:2] - 4'h4;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always @* begin
    rdMux = 32'h00000000;
    rdOk = 1'b1;
    if (s_axi_araddr[11:2] == `ACCFC_OFF_AGGR >> 2) begin
      rdMux = {26'h0000000, aggrCfg_r};
    end else if (s_axi_araddr[11:2] == `ACCFC_OFF_TYPEQ >> 2) begin
      rdMux = {17'h00000, typeQ_r};
    end else if (s_axi_araddr[11:2] == `ACCFC_OFF_STATUS >> 2) begin
      rdMux = {18'h00000, redirect_r, copy_r, aggrCode_r, cpuQueueMask_r};
    end else if (s_axi_araddr >= `ACCFC_OFF_ADDRQ &&
                 s_axi_araddr < `ACCFC_OFF_ADDRQ + 4 * `ACCFC_ADDRQ_WORDS)
    begin
      rdMux = {8'h00, addrQFlat[rdWord*24 +: 24]};
    end else if (rdPortHit && s_axi_araddr[3:2] == `ACCFC_SUB_TYPES) begin
      rdMux = {27'h0000000, typeEnaFlat[rdPortIdx*5 +: 5]};
    end else if (rdPortHit && s_axi_araddr[3:2] == `ACCFC_SUB_BPDU) begin
      rdMux = {16'h0000, bpduEnaFlat[rdPortIdx*16 +: 16]};
    end else if (rdPortHit && s_axi_araddr[3:2] == `ACCFC_SUB_GARP) begin
      rdMux = {16'h0000, garpEnaFlat[rdPortIdx*16 +: 16]};
    end else if (rdPortHit) begin
      rdMux = {16'h0000, ccmEnaFlat[rdPortIdx*16 +: 16]};
    end else begin
      rdOk = 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `ACCFC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdMux;
      rresp_r <= rdOk ? `ACCFC_RESP_OKAY : `ACCFC_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // accfc_classify
`default_nettype wire

// >>> testbench/accfc_classify_monitor.sv
// Port-level assertions for the classifier, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module accfc_monitor #(
  parameter NPORTS = 26
) (
  input wire clk_sys, // clock
  input wire sys_rst, // reset
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire [1:0] s_axi_bresp, // b resp
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // r data
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire frmValid, // frame valid
  input wire [7:0] extCpuQueueMask, // outside events
  input wire [NPORTS:0] fwdMaskIn, // normal mask
  input wire resValid, // result valid
  input wire [7:0] cpuQueueMask, // queue mask
  input wire [NPORTS:0] forwardPortMask, // final mask
  input wire cpuRedirect, // redirect
  input wire cpuCopy // copy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  AST_RES_LAT: assert property (frmValid |=> resValid)
    else $error("No result one cycle after a frame.");
  AST_RES_SRC: assert property (resValid |-> $past(frmValid))
    else $error("Result without a frame.");
  AST_REDIR: assert property (resValid && cpuRedirect |->
      forwardPortMask == {1'b1, {NPORTS{1'b0}}})
    else $error("Redirect left a front port set.");
  AST_COPY: assert property (frmValid ##1 !cpuRedirect |->
      forwardPortMask[NPORTS-1:0] == $past(fwdMaskIn[NPORTS-1:0]))
    else $error("Front ports changed without redirect.");
  AST_EXT_OR: assert property (frmValid |=>
      (cpuQueueMask & $past(extCpuQueueMask)) == $past(extCpuQueueMask))
    else $error("Outside queue event lost.");
  AST_Q_SET: assert property ((cpuRedirect || cpuCopy) && resValid |->
      cpuQueueMask != 8'h00 && forwardPortMask[NPORTS])
    else $error("CPU forward with no queue.");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("Write response late.");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early.");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid)
    else $error("Read data late.");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early.");
  cover property (resValid && cpuRedirect);
  cover property (resValid && cpuCopy);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // accfc_monitor

bind accfc_classify accfc_monitor #(.NPORTS(NPORTS)) u_accfc_monitor (.*);
`default_nettype wire

// >>> testbench/accfc_fwd_model.sv
// Forwarding engine stand-in: offers the normal mask and counts results.
`timescale 1ns/1ps
`default_nettype none
module accfc_fwd_model #(
  parameter NPORTS = 26
) (
  input wire logic clk_sys, // clock
  input wire logic resValid, // result pulse
  output var logic [NPORTS:0] fwdMaskIn, // normal forward mask
  output var logic [7:0] extCpuQueueMask // outside queue events
);
  int resCount = 0;
  initial begin
    fwdMaskIn = '0;
    extCpuQueueMask = 8'h00;
  end
  // Counting pulses catches a result that lasts two cycles or never comes.
  always @(posedge clk_sys) begin
    if (resValid) resCount <= resCount + 1;
  end
  task automatic offer(input logic [NPORTS:0] f, input logic [7:0] e);
    @(posedge clk_sys);
    fwdMaskIn <= f;
    extCpuQueueMask <= e;
  endtask
endmodule // accfc_fwd_model
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the aggregation and CPU forwarding classifier.
`timescale 1ns/1ps
`default_nettype none
`include "accfc_defs.vh"
module testbench;
  localparam logic [1:0] OK = `ACCFC_RESP_OKAY;
  localparam logic [26:0] FWD = 27'h0001234;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] awAddr = 12'h000;
  logic [11:0] arAddr = 12'h000;
  logic [31:0] wData = 32'h00000000;
  logic [3:0] wStrb = 4'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0, frmValid = 1'b0;
  logic isIp4 = 1'b0, isIp6 = 1'b0, l4v = 1'b1;
  logic [4:0] port = 5'h00;
  logic [47:0] dmac = 48'h000000000ABC;
  logic [47:0] smac = 48'h000000000125;
  logic [7:0] proto = 8'h11;
  logic [31:0] sip = 32'h0A000037;
  logic [31:0] dip = 32'hE0000052;
  logic [19:0] flow = 20'h12345;
  logic [15:0] sport = 16'h006A;
  logic [15:0] dport = 16'h001F;
  logic [31:0] opt = 32'h05020000;
  wire [26:0] fwdIn, forwardPortMask;
  wire [7:0] extQ, cpuQueueMask;
  wire awReady, wReady, bValid, arReady, rValid, resValid, cpuRedirect, cpuCopy;
  wire [1:0] bResp, rResp;
  wire [31:0] rData;
  wire [3:0] aggrCode;
  int n_mismatch = 0;
  int num_checks = 0;
  int nSent = 0;

  accfc_classify u_accfc_classify (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .frmValid(frmValid), .frmPort(port),
    .frmDmac(dmac), .frmSmac(smac), .frmIsIp4(isIp4), .frmIsIp6(isIp6),
    .frmL4Valid(l4v), .frmIpProto(proto), .frmSip(sip), .frmDip(dip),
    .frmFlowLabel(flow), .frmSport(sport), .frmDport(dport),
    .frmOptType(opt[31:24]), .frmOptLen(opt[23:16]), .frmOptData(opt[15:0]),
    .extCpuQueueMask(extQ), .fwdMaskIn(fwdIn), .resValid(resValid),
    .aggrCode(aggrCode), .cpuQueueMask(cpuQueueMask),
    .forwardPortMask(forwardPortMask), .cpuRedirect(cpuRedirect),
    .cpuCopy(cpuCopy)
  );
  accfc_fwd_model #(.NPORTS(26)) u_accfc_fwd_model (.clk_sys(clk_sys),
    .resValid(resValid), .fwdMaskIn(fwdIn), .extCpuQueueMask(extQ));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrReg(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF, input logic [1:0] er = OK);
    int n;
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    // Ready rises in the same cycle as the response, so a held response is not tested.
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bReady && bValid) break;
      if (n == 1) bReady <= 1'b1;
    end
    bReady <= 1'b0;
    chk({n < 40, bResp}, {1'b1, er});
  endtask

  task automatic rdReg(input logic [11:0] a, input logic [31:0] ed,
      input logic [1:0] er = OK);
    int n;
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (arValid && arReady) arValid <= 1'b0;
      if (rReady && rValid) break;
      if (n == 1) rReady <= 1'b1;
    end
    rReady <= 1'b0;
    chk({n < 40, rResp, rData}, {1'b1, er, ed});
  endtask

  task automatic snd(input logic [4:0] p, input logic [47:0] d,
      input logic [1:0] ip, input logic [7:0] pr);
    @(posedge clk_sys);
    frmValid <= 1'b1;
    port <= p;
    dmac <= d;
    isIp4 <= ip[0];
    isIp6 <= ip[1];
    proto <= pr;
    @(posedge clk_sys);
    frmValid <= 1'b0;
    nSent++;
    #1;
  endtask

  task automatic cpuf(input logic [47:0] d, input logic [1:0] ip,
      input logic [7:0] pr, input logic [7:0] q, input logic redir,
      input logic [4:0] p = 5'd3);
    snd(p, d, ip, pr);
    chk({resValid, cpuRedirect, cpuCopy, cpuQueueMask},
        {1'b1, redir, !redir && q != 8'h00, q});
    chk(forwardPortMask, redir ? {1'b1, 26'h0} : {q != 8'h00, FWD[25:0]});
  endtask

  task automatic t_regs();
    rdReg(`ACCFC_OFF_AGGR, 32'h0);
    rdReg(`ACCFC_OFF_TYPEQ, 32'h0);
    rdReg(`ACCFC_OFF_PORT + 12'h030, 32'h0);
    rdReg(12'h0FC, 32'h0, `ACCFC_RESP_SLVERR);
    wrReg(12'h0FC, 32'hFFFFFFFF, 4'hF, `ACCFC_RESP_SLVERR);
    wrReg(`ACCFC_OFF_STATUS, 32'hFFFFFFFF);
    rdReg(`ACCFC_OFF_STATUS, 32'h0);
    wrReg(`ACCFC_OFF_AGGR, 32'h3F, 4'h0);
    rdReg(`ACCFC_OFF_AGGR, 32'h0);
    wrReg(`ACCFC_OFF_AGGR, 32'hFFFFFFFF);
    rdReg(`ACCFC_OFF_AGGR, 32'h3F);
  endtask

  task automatic t_aggr();
    logic [5:0] cf [12] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h10, 6'h04,
                            6'h10, 6'h1F, 6'h10, 6'h02, 6'h04, 6'h1B};
    logic [47:0] ex = 48'h5E90A21236D0;
    logic [11:0] six = 12'h460;
    for (int i = 0; i < 12; i++) begin
      wrReg(`ACCFC_OFF_AGGR, {26'h0, cf[i]});
      @(posedge clk_sys);
      l4v <= (i != 8);
      // Inverting flips odd nibble counts only, so MAC and flow codes move.
      if (i == 9) {smac, flow, sip, dip, sport, dport} <= ~{smac, flow, sip,
          dip, sport, dport};
      snd(5'd0, 48'h000000000ABC, six[i] ? 2'd2 : 2'd1, 8'h11);
      chk(aggrCode, ex[4*i+:4]);
    end
    @(posedge clk_sys);
    {smac, flow, sip, dip, sport, dport} <= ~{smac, flow, sip, dip, sport,
        dport};
  endtask

  task automatic t_rand();
    logic [3:0] first;
    int diff;
    diff = 0;
    first = 4'h0;
    wrReg(`ACCFC_OFF_AGGR, 32'h20);
    for (int i = 0; i < 8; i++) begin
      snd(5'd0, dmac, 2'd1, 8'h11);
      if (i == 0) first = aggrCode;
      else if (aggrCode !== first) diff++;
    end
    chk(diff != 0, 1'b1);
  endtask

  task automatic t_cpu();
    wrReg(`ACCFC_OFF_AGGR, 32'h0);
    wrReg(12'h130, 32'h0F);
    wrReg(12'h134, 32'hFFFF);
    wrReg(12'h138, 32'hFFFF);
    wrReg(12'h13C, 32'hFFFF);
    wrReg(`ACCFC_OFF_TYPEQ, 32'h58D1);
    wrReg(`ACCFC_OFF_ADDRQ, 32'hDB6DB6);
    wrReg(`ACCFC_OFF_ADDRQ + 12'h008, 32'hFFFFFF);
    rdReg(`ACCFC_OFF_TYPEQ, 32'h58D1);
    u_accfc_fwd_model.offer(FWD, 8'h00);
    cpuf(48'h0180C2000005, 2'd0, 8'h11, 8'h40, 1'b1);
    cpuf(48'h0180C200000F, 2'd0, 8'h11, 8'h01, 1'b1);
    cpuf(48'h0180C2000010, 2'd0, 8'h11, 8'h02, 1'b1);
    cpuf(48'h0180C2000023, 2'd0, 8'h11, 8'h80, 1'b1);
    cpuf(48'h0180C2000031, 2'd0, 8'h11, 8'h01, 1'b1);
    cpuf(48'h01005E000001, 2'd1, 8'h02, 8'h04, 1'b1);
    cpuf(48'h01005E800001, 2'd1, 8'h02, 8'h00, 1'b0);
    cpuf(48'h333300000001, 2'd2, 8'h00, 8'h08, 1'b1);
    cpuf(48'h333300000001, 2'd1, 8'h00, 8'h00, 1'b0);
    cpuf(48'h01005E000001, 2'd1, 8'h11, 8'h10, 1'b0);
    cpuf(48'h001122334455, 2'd1, 8'h11, 8'h00, 1'b0);
    cpuf(48'h0180C2000005, 2'd0, 8'h11, 8'h00, 1'b0, 5'd4);
    wrReg(12'h134, 32'hFFDF);
    cpuf(48'h0180C2000005, 2'd0, 8'h11, 8'h00, 1'b0);
    u_accfc_fwd_model.offer(FWD, 8'h80);
    cpuf(48'h0180C2000010, 2'd0, 8'h11, 8'h82, 1'b1);
    u_accfc_fwd_model.offer(FWD, 8'h00);
    wrReg(12'h130, 32'h10);
    cpuf(48'h0180C2000010, 2'd0, 8'h11, 8'h20, 1'b0);
    rdReg(`ACCFC_OFF_STATUS, 32'h1020);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // About 250 cycles are needed.
  initial begin
    repeat (8000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_aggr();
    t_rand();
    t_cpu();
    chk(u_accfc_fwd_model.resCount, nSent);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
